// >>> rtl/ckg_pkg.sv
// Purpose: Shared constants and carriers for the system and auxiliary clock generator.
// Assumes: Frequencies are carried as unsigned hertz values, FREQ_W bits wide.
// Notes: Source codes follow the 3-bit selection encoding used by software.
package ckg_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 10;
  localparam int unsigned FAIL_TIME_US = 2000;
  localparam int unsigned FAIL_CYC_DFLT = FAIL_TIME_US * CLK_MHZ;

  // ----------------------------------------------------------------
  // Source selection codes
  // ----------------------------------------------------------------
  localparam logic [2:0] SRC_FAST = 3'h0;
  localparam logic [2:0] SRC_FAST_PLL = 3'h1;
  localparam logic [2:0] SRC_PRI = 3'h2;
  localparam logic [2:0] SRC_PRI_PLL = 3'h3;
  localparam logic [2:0] SRC_RSVD = 3'h4;
  localparam logic [2:0] SRC_LOWP = 3'h5;
  localparam logic [2:0] SRC_FAST_16 = 3'h6;
  localparam logic [2:0] SRC_FAST_DIVN = 3'h7;
  localparam logic [2:0] SRC_ERASED = SRC_FAST_DIVN;

  localparam logic [1:0] PMODE_EXT = 2'h0;
  localparam logic [1:0] PMODE_MED = 2'h1;
  localparam logic [1:0] PMODE_HIGH = 2'h2;
  localparam logic [1:0] PMODE_OFF = 2'h3;

  // ----------------------------------------------------------------
  // Dividers and multipliers
  // ----------------------------------------------------------------
  localparam int unsigned FREQ_W = 32;
  localparam int unsigned PROD_W = FREQ_W + 10;
  localparam logic [3:0] FAST_16_SHIFT = 4'h4;
  localparam logic [2:0] FAST_DIV_MAX_CODE = 3'h7;
  localparam logic [3:0] FAST_DIV_MAX_SHIFT = 4'h8;
  localparam logic [5:0] PLL_IN_OFS = 6'h02;
  localparam logic [9:0] PLL_FB_OFS = 10'h002;
  localparam logic [2:0] PLL_OUT_OFS = 3'h1;
  localparam int unsigned AUX_PLL_MULT = 16;
  localparam logic [2:0] AUX_POST_DIV1 = 3'h7;
  localparam logic [FREQ_W-1:0] PWM_AUX_HZ = 32'h07270E00;

  // ----------------------------------------------------------------
  // Oscillator monitor channels
  // ----------------------------------------------------------------
  localparam int unsigned MON_N = 5;
  localparam int unsigned MON_PRI = 0;
  localparam int unsigned MON_FAST = 1;
  localparam int unsigned MON_LOWP = 2;
  localparam int unsigned MON_PLL = 3;
  localparam int unsigned MON_AUX = 4;

  typedef enum logic [1:0] {
    SW_IDLE = 2'h0,
    SW_WAIT = 2'h1,
    SW_DONE = 2'h3
  } ckg_sw_e;

  typedef struct packed {
    logic osc2_pin_function_cfg;
    logic [1:0] primary_osc_mode_cfg;
    logic [2:0] initial_source_cfg;
  } ckg_cfg_s;

  typedef struct packed {
    logic switch_request_bit;
    logic [2:0] new_source_field;
    logic [4:0] pll_input_divider;
    logic [1:0] pll_output_divider;
    logic [8:0] pll_feedback_divider;
    logic ratio_enable;
    logic [2:0] doze_ratio;
    logic [2:0] fast_rc_postdiv;
    logic aux_src_fast;
    logic aux_use_pll;
    logic [2:0] aux_clock_postscaler;
    logic fail_clear;
  } ckg_ctrl_s;

  typedef struct packed {
    logic [FREQ_W-1:0] osc_hz;
    logic [FREQ_W-1:0] instr_hz;
    logic [FREQ_W-1:0] periph_hz;
    logic [FREQ_W-1:0] cpu_hz;
    logic [FREQ_W-1:0] vco_hz;
    logic [FREQ_W-1:0] pllo_hz;
    logic [FREQ_W-1:0] aux_hz;
  } ckg_freq_s;

  typedef struct packed {
    logic [2:0] cur_source;
    logic switch_request_bit;
    logic clock_fail;
    logic pll_locked;
    logic osc2_io;
    logic fine_res;
    logic pwm_ready;
  } ckg_stat_s;

endpackage

// >>> rtl/ckg_edge_mon.sv
// Purpose: Synchronise one oscillator or lock pin and judge whether it is alive.
// Assumes: The pin toggles slower than half the reference clock.
// Notes: Alive drops when no filtered edge is seen for TIMEOUT cycles.
`timescale 1ns/10ps
module ckg_edge_mon import ckg_pkg::*; #(
  parameter int unsigned TIMEOUT = FAIL_CYC_DFLT
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_raw,
  output logic o_level,
  output logic o_alive
);
  localparam int unsigned CNT_W = $clog2(TIMEOUT + 1);

  if (TIMEOUT < 2) begin : g_chk
    $error("TIMEOUT must be at least 2");
  end

  typedef struct packed {
    logic [2:0] sync;
    logic filt;
    logic [CNT_W-1:0] cnt;
    logic alive;
  } ckg_mon_st_s;

  ckg_mon_st_s mon_ff;
  ckg_mon_st_s nxt_mon;

  always_comb begin
    nxt_mon = mon_ff;
    nxt_mon.sync = {mon_ff.sync[1:0], i_raw};
    // A change counts once the second and third stages agree
    if (mon_ff.sync[1] == mon_ff.sync[2]) begin
      nxt_mon.filt = mon_ff.sync[2];
    end
    if (nxt_mon.filt != mon_ff.filt) begin
      nxt_mon.cnt = '0;
    end else if (mon_ff.cnt != CNT_W'(TIMEOUT)) begin
      nxt_mon.cnt = mon_ff.cnt + 1'b1;
    end
    nxt_mon.alive = (nxt_mon.cnt != CNT_W'(TIMEOUT));
    if (i_rst) begin
      nxt_mon = '0;
      nxt_mon.alive = 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    mon_ff <= nxt_mon;
  end

  assign o_level = mon_ff.filt;
  assign o_alive = mon_ff.alive;

endmodule

// >>> rtl/ckg_clock_gen.sv
// Purpose: System clock source selection, switching, failure fallback and rate tracking.
// Assumes: Oscillator and lock pins are asynchronous; rates are given in hertz.
// Notes: Outputs describe the clocks; actual gating happens at the consumers.
//
// Behaviour
// - Three-bit code selects one of seven sources
// - Primary mode code picks crystal or external
// - Erased configuration starts on divided fast RC
// - Instruction clock is oscillator clock halved
// - PLL output is input times M/(N1*N2)
// - VCO rate is input times M/N1
// - CPU equals peripheral clock except under doze
// - Auxiliary PLL multiplies input by sixteen
// - Aux PLL input is primary or fast RC
// - Aux clock runs independent of system clock
// - Fine PWM resolution only via aux PLL
// - Source switches on the fly without reset
// - Lost oscillator behind active source other than plain fast RC is detected and recovered; PLL unlock is not
// - Dedicated bit sets second oscillator pin function
// - Switch request starts switch, clears when done
// - Output divider codes give two, four, six, eight
// - Doze ratio divides CPU clock up to 128
`timescale 1ns/10ps
module ckg_clock_gen import ckg_pkg::*; #(
  parameter int unsigned FAIL_CYC = FAIL_CYC_DFLT
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire ckg_cfg_s i_cfg,
  input wire ckg_ctrl_s i_ctrl,
  input wire logic [MON_N-1:0] i_osc_raw,
  input wire logic [FREQ_W-1:0] i_pri_hz,
  input wire logic [FREQ_W-1:0] i_fast_rc_hz,
  input wire logic [FREQ_W-1:0] i_low_rc_hz,
  output ckg_freq_s o_freq,
  output ckg_stat_s o_stat
);

  if (FAIL_CYC < 2 || FAIL_CYC > 1048575) begin : g_chk
    $error("FAIL_CYC out of range");
  end

  typedef struct packed {
    ckg_sw_e state;
    logic [2:0] cur;
    logic [2:0] tgt;
    logic fail;
    logic osc2_io;
    logic fine_res;
    logic pwm_ready;
    ckg_freq_s freq;
  } ckg_st_s;

  ckg_st_s st_ff;
  ckg_st_s nxt_st;

  // ----------------------------------------------------------------
  // Pin monitors
  // ----------------------------------------------------------------
  logic [MON_N-1:0] mon_level;
  logic [MON_N-1:0] mon_alive;

  for (genvar gi = 0; gi < MON_N; gi++) begin : g_mon
    ckg_edge_mon #(.TIMEOUT(FAIL_CYC)) u_mon (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_raw(i_osc_raw[gi]),
      .o_level(mon_level[gi]),
      .o_alive(mon_alive[gi])
    );
  end

  function automatic logic src_ok(input logic [2:0] code, input logic pri, input logic fast,
                                  input logic lowp, input logic lock);
    case (code)
      SRC_FAST, SRC_FAST_16, SRC_FAST_DIVN: src_ok = fast;
      SRC_FAST_PLL: src_ok = fast & lock;
      SRC_PRI: src_ok = pri;
      SRC_PRI_PLL: src_ok = pri & lock;
      SRC_LOWP: src_ok = lowp;
      default: src_ok = 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Rate arithmetic
  // ----------------------------------------------------------------
  logic pri_ok;
  logic pll_lock;
  logic aux_lock;
  logic ratio_on;
  logic cur_is_pll;
  logic cur_dead;
  logic tgt_ready;
  logic illegal;
  logic [3:0] fast_shift;
  logic [FREQ_W-1:0] fast_n_hz;
  logic [FREQ_W-1:0] pll_in_hz;
  logic [FREQ_W-1:0] aux_in_hz;
  logic [FREQ_W-1:0] sel_hz;
  logic [5:0] n1;
  logic [3:0] n2;
  logic [9:0] m;
  logic [9:0] n12;
  logic [PROD_W-1:0] prod;

  always_comb begin
    // primary usable only in a crystal or external mode
    pri_ok = (i_cfg.primary_osc_mode_cfg != PMODE_OFF) && mon_alive[MON_PRI];
    pll_lock = mon_level[MON_PLL];
    aux_lock = mon_level[MON_AUX];
    ratio_on = i_ctrl.ratio_enable && (i_ctrl.doze_ratio != 3'h0);
    cur_is_pll = (st_ff.cur == SRC_PRI_PLL) || (st_ff.cur == SRC_FAST_PLL);
    cur_dead = !src_ok(st_ff.cur, pri_ok, mon_alive[MON_FAST], mon_alive[MON_LOWP], 1'b1)
               && (st_ff.cur != SRC_FAST) && (st_ff.cur != SRC_RSVD);
    tgt_ready = src_ok(st_ff.tgt, pri_ok, mon_alive[MON_FAST], mon_alive[MON_LOWP], pll_lock);
    // direct hops between the two PLL modes are refused
    illegal = (i_ctrl.new_source_field == SRC_RSVD)
              || (i_ctrl.new_source_field == SRC_PRI_PLL && st_ff.cur == SRC_FAST_PLL)
              || (i_ctrl.new_source_field == SRC_FAST_PLL && st_ff.cur == SRC_PRI_PLL);
    fast_shift = (i_ctrl.fast_rc_postdiv == FAST_DIV_MAX_CODE) ? FAST_DIV_MAX_SHIFT
                 : {1'b0, i_ctrl.fast_rc_postdiv};
    fast_n_hz = i_fast_rc_hz >> fast_shift;
    pll_in_hz = (st_ff.cur == SRC_FAST_PLL) ? fast_n_hz : i_pri_hz;
    n1 = {1'b0, i_ctrl.pll_input_divider} + PLL_IN_OFS;
    m = {1'b0, i_ctrl.pll_feedback_divider} + PLL_FB_OFS;
    n2 = {({1'b0, i_ctrl.pll_output_divider} + PLL_OUT_OFS), 1'b0};
    n12 = 10'(n1) * 10'(n2);
    prod = PROD_W'(pll_in_hz) * PROD_W'(m);
    // aux PLL input is primary or fast RC
    aux_in_hz = i_ctrl.aux_src_fast ? i_fast_rc_hz : i_pri_hz;
    case (st_ff.cur)
      SRC_FAST: sel_hz = i_fast_rc_hz;
      SRC_FAST_DIVN: sel_hz = fast_n_hz;
      SRC_FAST_16: sel_hz = i_fast_rc_hz >> FAST_16_SHIFT;
      SRC_LOWP: sel_hz = i_low_rc_hz;
      SRC_PRI: sel_hz = i_pri_hz;
      SRC_PRI_PLL, SRC_FAST_PLL: sel_hz = pll_lock ? FREQ_W'(prod / PROD_W'(n12)) : '0;
      default: sel_hz = '0;
    endcase
  end

  // ----------------------------------------------------------------
  // Switch sequencer and next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.osc2_io = i_cfg.osc2_pin_function_cfg;
    nxt_st.freq.osc_hz = sel_hz;
    nxt_st.freq.instr_hz = sel_hz >> 1;
    nxt_st.freq.periph_hz = sel_hz >> 1;
    nxt_st.freq.cpu_hz = ratio_on ? ((sel_hz >> 1) >> i_ctrl.doze_ratio) : (sel_hz >> 1);
    nxt_st.freq.vco_hz = FREQ_W'(prod / PROD_W'(n1));
    nxt_st.freq.pllo_hz = FREQ_W'(prod / PROD_W'(n12));
    // aux rate, independent of the system source
    if (!i_ctrl.aux_use_pll) begin
      nxt_st.freq.aux_hz = aux_in_hz;
    end else if (aux_lock) begin
      nxt_st.freq.aux_hz = FREQ_W'(aux_in_hz * AUX_PLL_MULT);
    end else begin
      nxt_st.freq.aux_hz = '0;
    end
    nxt_st.fine_res = i_ctrl.aux_use_pll && aux_lock;
    // PWM ready only with 120 MHz and unity postscaler
    nxt_st.pwm_ready = (nxt_st.freq.aux_hz == PWM_AUX_HZ)
                       && (i_ctrl.aux_clock_postscaler == AUX_POST_DIV1);
    if (i_ctrl.fail_clear) begin
      nxt_st.fail = 1'b0;
    end
    case (st_ff.state)
      SW_IDLE: begin
        if (i_ctrl.switch_request_bit && !illegal) begin
          nxt_st.tgt = i_ctrl.new_source_field;
          nxt_st.state = SW_WAIT;
        end
      end
      SW_WAIT: begin
        if (tgt_ready) begin
          nxt_st.cur = st_ff.tgt;
          nxt_st.state = SW_DONE;
        end
      end
      SW_DONE: nxt_st.state = SW_IDLE;
      default: nxt_st.state = SW_IDLE;
    endcase
    // fall back to fast RC on loss; set wins over clear
    if (cur_dead) begin
      nxt_st.cur = SRC_FAST;
      nxt_st.fail = 1'b1;
      nxt_st.state = SW_IDLE;
    end
    if (i_rst) begin
      nxt_st = '0;
      nxt_st.state = SW_IDLE;
      nxt_st.cur = i_cfg.initial_source_cfg;
      nxt_st.osc2_io = i_cfg.osc2_pin_function_cfg;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    st_ff <= nxt_st;
  end

  assign o_freq = st_ff.freq;
  assign o_stat = '{cur_source: st_ff.cur, switch_request_bit: (st_ff.state != SW_IDLE),
                    clock_fail: st_ff.fail, pll_locked: pll_lock, osc2_io: st_ff.osc2_io,
                    fine_res: st_ff.fine_res, pwm_ready: st_ff.pwm_ready};

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  instr_half_a: assert property (o_freq.instr_hz == (o_freq.osc_hz >> 1))
    else $error("instruction rate not half of oscillator rate");
  cpu_eq_a: assert property (!ratio_on |=> o_freq.cpu_hz == o_freq.periph_hz)
    else $error("cpu rate differs from peripheral rate outside doze");
  doze_div_a: assert property (ratio_on |=>
    o_freq.cpu_hz == (o_freq.instr_hz >> $past(i_ctrl.doze_ratio)))
    else $error("doze ratio not applied");
  sw_start_a: assert property ((st_ff.state == SW_IDLE && i_ctrl.switch_request_bit
    && !illegal && !cur_dead) |=> o_stat.switch_request_bit)
    else $error("switch request not taken");
  sw_refuse_a: assert property ((st_ff.state == SW_IDLE && i_ctrl.switch_request_bit
    && illegal && !cur_dead) |=> !o_stat.switch_request_bit)
    else $error("illegal switch was started");
  sw_hold_a: assert property ((st_ff.state == SW_WAIT && !tgt_ready && !cur_dead)
    |=> $stable(st_ff.cur))
    else $error("source moved before target was ready");
  sw_done_a: assert property ((st_ff.state == SW_WAIT && tgt_ready && !cur_dead)
    |=> (st_ff.cur == $past(st_ff.tgt)) ##1 !o_stat.switch_request_bit)
    else $error("switch did not complete in two cycles");
  pll_gate_a: assert property ((cur_is_pll && !pll_lock) |=> o_freq.osc_hz == '0)
    else $error("unlocked PLL rate reached the system clock");
  aux_mult_a: assert property ((i_ctrl.aux_use_pll && aux_lock)
    |=> o_freq.aux_hz == FREQ_W'($past(aux_in_hz) * AUX_PLL_MULT))
    else $error("aux PLL not sixteen times input");
  fine_res_a: assert property (o_stat.fine_res |-> $past(i_ctrl.aux_use_pll))
    else $error("fine resolution without aux PLL");
  fail_back_a: assert property (cur_dead |=> st_ff.cur == SRC_FAST && o_stat.clock_fail)
    else $error("no fallback after clock loss");
  osc2_fn_a: assert property (##1 o_stat.osc2_io == $past(i_cfg.osc2_pin_function_cfg))
    else $error("second pin function not following its bit");

  sw_done_c: cover property (st_ff.state == SW_WAIT ##1 st_ff.state == SW_DONE);
  fail_c: cover property (cur_dead ##1 o_stat.clock_fail);
  doze_c: cover property (ratio_on ##1 o_freq.cpu_hz != o_freq.periph_hz);
  fine_c: cover property (o_stat.fine_res && o_stat.pwm_ready);

endmodule

// >>> verification/ckg_osc_model.sv
// Purpose: Behavioural oscillators and lock levels that face the clock generator.
// Assumes: Every pin toggles well below half the reference clock rate.
// Notes: A stopped oscillator sits low, the way a dead crystal does.
`timescale 1ns/10ps
module ckg_osc_model import ckg_pkg::*; (
  input wire logic [2:0] i_run,
  input wire logic [1:0] i_lock,
  output logic [MON_N-1:0] o_osc_raw
);
  logic [2:0] ph;

  // Unrelated half periods keep the three sources out of step
  initial begin
    ph = 3'h0;
    // Offset keeps every toggle away from the reference clock edges
    #7;
    fork
      forever #250 ph[0] = ~ph[0];
      forever #350 ph[1] = ~ph[1];
      forever #450 ph[2] = ~ph[2];
    join
  end

  // Clearing a run bit models a lost oscillator; lock pins are plain levels
  assign o_osc_raw = {i_lock, ph & i_run};
endmodule

// >>> verification/testbench.sv
// Purpose: Self-checking bench for the system and auxiliary clock generator.
// Assumes: A short failure timeout and oscillator pins from the partner model.
// Notes: Each scenario is one task that drives the block and judges the result.
`timescale 1ns/10ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("MISMATCH %0t got %0h exp %0h", $time, g, e); end end
module testbench import ckg_pkg::*;;
  localparam int unsigned FCYC = 32;
  localparam logic [FREQ_W-1:0] PRI = 32'h007270E0;
  localparam logic [FREQ_W-1:0] FAST = 32'h007A1200;
  localparam logic [FREQ_W-1:0] LOW = 32'h00007D00;
  logic i_ref_clk;
  logic i_rst;
  ckg_cfg_s cfg;
  ckg_ctrl_s ctrl;
  logic [2:0] run;
  logic [1:0] lock;
  logic [MON_N-1:0] osc_raw;
  ckg_freq_s freq;
  ckg_stat_s stat;
  int num_errors;
  int total_checks;

  ckg_osc_model osc (.i_run(run), .i_lock(lock), .o_osc_raw(osc_raw));
  ckg_clock_gen #(.FAIL_CYC(FCYC)) dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_cfg(cfg),
    .i_ctrl(ctrl), .i_osc_raw(osc_raw), .i_pri_hz(PRI), .i_fast_rc_hz(FAST),
    .i_low_rc_hz(LOW), .o_freq(freq), .o_stat(stat));

  initial begin
    i_ref_clk = 1'b0;
    forever #50 i_ref_clk = ~i_ref_clk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic tick(int n = 1);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask

  task automatic start_sw(logic [2:0] code);
    ctrl.new_source_field = code;
    ctrl.switch_request_bit = 1'b1;
    tick();
    ctrl.switch_request_bit = 1'b0;
    tick();
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (stat.switch_request_bit !== 1'b0 && n < 200) begin
      tick();
      n++;
    end
    `CHK(stat.switch_request_bit, 1'b0)
    tick(3);
  endtask

  task automatic sw(logic [2:0] code);
    start_sw(code);
    wait_idle();
    `CHK(stat.cur_source, code)
  endtask

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    `CHK(stat.cur_source, SRC_ERASED)
    `CHK(stat.osc2_io, cfg.osc2_pin_function_cfg)
    `CHK(freq.osc_hz, FAST)
    `CHK(freq.instr_hz, FAST >> 1)
    `CHK(freq.periph_hz, FAST >> 1)
    `CHK(freq.cpu_hz, FAST >> 1)
  endtask

  task automatic t_sources();
    logic [2:0] codes [5] = '{3'h6, 3'h5, 3'h2, 3'h0, 3'h7};
    logic [FREQ_W-1:0] want [5];
    want = '{FAST >> 4, LOW, PRI, FAST, FAST >> 3};
    ctrl.fast_rc_postdiv = 3'h3;
    foreach (codes[i]) begin
      sw(codes[i]);
      `CHK(freq.osc_hz, want[i])
      `CHK(freq.instr_hz, want[i] >> 1)
    end
    ctrl.fast_rc_postdiv = 3'h7;
    tick(3);
    `CHK(freq.osc_hz, FAST >> 8)
  endtask

  task automatic t_pll();
    logic [1:0] posts [3] = '{2'h0, 2'h1, 2'h3};
    logic [63:0] vco;
    logic [FREQ_W-1:0] e;
    ctrl.pll_input_divider = 5'h01;
    ctrl.pll_feedback_divider = 9'h02E;
    vco = 64'(PRI) * 48 / 3;
    start_sw(SRC_PRI_PLL);
    tick(20);
    `CHK(stat.switch_request_bit, 1'b1)
    `CHK(stat.cur_source, SRC_FAST_DIVN)
    lock[0] = 1'b1;
    wait_idle();
    `CHK(stat.cur_source, SRC_PRI_PLL)
    `CHK(stat.pll_locked, 1'b1)
    `CHK(freq.vco_hz, vco[31:0])
    foreach (posts[i]) begin
      ctrl.pll_output_divider = posts[i];
      tick(3);
      e = vco[31:0] / (32'(posts[i]) * 2 + 2);
      `CHK(freq.pllo_hz, e)
      `CHK(freq.osc_hz, e)
    end
    lock[0] = 1'b0;
    tick(6);
    `CHK(stat.pll_locked, 1'b0)
    `CHK(freq.osc_hz, 32'h00000000)
    lock[0] = 1'b1;
    tick(6);
    start_sw(SRC_FAST_PLL);
    `CHK(stat.switch_request_bit, 1'b0)
    `CHK(stat.cur_source, SRC_PRI_PLL)
    sw(SRC_FAST);
    sw(SRC_FAST_PLL);
    `CHK(freq.osc_hz, (FAST >> 8) * 48 / 24)
    start_sw(SRC_PRI_PLL);
    `CHK(stat.cur_source, SRC_FAST_PLL)
    start_sw(SRC_RSVD);
    `CHK(stat.switch_request_bit, 1'b0)
    sw(SRC_FAST);
  endtask

  task automatic t_doze();
    ctrl.ratio_enable = 1'b1;
    for (int r = 0; r < 8; r++) begin
      ctrl.doze_ratio = 3'(r);
      tick(3);
      `CHK(freq.cpu_hz, (FAST >> 1) >> r)
      `CHK(freq.periph_hz, FAST >> 1)
    end
    ctrl.ratio_enable = 1'b0;
    tick(3);
    `CHK(freq.cpu_hz, FAST >> 1)
  endtask

  task automatic t_aux();
    ctrl.aux_src_fast = 1'b0;
    ctrl.aux_use_pll = 1'b0;
    tick(3);
    `CHK(freq.aux_hz, PRI)
    `CHK(stat.fine_res, 1'b0)
    ctrl.aux_use_pll = 1'b1;
    tick(3);
    `CHK(freq.aux_hz, 32'h00000000)
    lock[1] = 1'b1;
    tick(6);
    `CHK(freq.aux_hz, PRI * 16)
    `CHK(stat.fine_res, 1'b1)
    `CHK(stat.pwm_ready, 1'b1)
    ctrl.aux_src_fast = 1'b1;
    tick(3);
    `CHK(freq.aux_hz, FAST * 16)
    `CHK(stat.pwm_ready, 1'b0)
  endtask

  task automatic t_fail();
    int n;
    cfg.primary_osc_mode_cfg = PMODE_OFF;
    start_sw(SRC_PRI);
    tick(4);
    `CHK(stat.switch_request_bit, 1'b1)
    `CHK(stat.cur_source, SRC_FAST)
    cfg.primary_osc_mode_cfg = PMODE_EXT;
    wait_idle();
    `CHK(stat.cur_source, SRC_PRI)
    run[0] = 1'b0;
    tick(16);
    `CHK(stat.clock_fail, 1'b0)
    n = 0;
    while (stat.clock_fail !== 1'b1 && n < 60) begin
      tick();
      n++;
    end
    `CHK(stat.clock_fail, 1'b1)
    `CHK(stat.cur_source, SRC_FAST)
    tick(2);
    `CHK(freq.osc_hz, FAST)
    ctrl.fail_clear = 1'b1;
    tick();
    ctrl.fail_clear = 1'b0;
    tick();
    `CHK(stat.clock_fail, 1'b0)
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    i_rst = 1'b1;
    cfg.osc2_pin_function_cfg = 1'b1;
    cfg.primary_osc_mode_cfg = PMODE_HIGH;
    cfg.initial_source_cfg = SRC_ERASED;
    ctrl = '0;
    ctrl.aux_clock_postscaler = AUX_POST_DIV1;
    run = 3'h7;
    lock = 2'h0;
    num_errors = 0;
    total_checks = 0;
    tick(3);
    i_rst = 1'b0;
    tick(3);
    t_reset();
    t_sources();
    t_pll();
    t_doze();
    t_aux();
    t_fail();
    give_verdict();
  end

  initial begin
    #5000000;
    num_errors++;
    give_verdict();
  end
endmodule
